// ==== rtl/sprw_pkg.sv ====
/*
 package of the self-program concurrent-read controller: register map,
 field positions, reset values, lock decode and flash geometry.
 assumes one core clock and a 32-bit Avalon-MM register master.
*/
package sprw_pkg;
	// ==========================================
	// flash geometry, page addresses
	localparam int PAGE_W = 9;
	localparam logic [PAGE_W-1:0] STALL_FIRST_PAGE = 9'h1C0;
	localparam logic [PAGE_W-1:0] PAGE_TOP = 9'h1FF;
	localparam int OP_CYCLES_W = 20;
	localparam real OP_TIME_US = 4500.0;
	localparam real CLK_MHZ = 25.0;
	localparam int OP_CYCLES = int'(OP_TIME_US * CLK_MHZ);
	// ==========================================
	// register map, byte addresses
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STAT_ADDR = 8'h04;
	localparam logic [7:0] LOCK_ADDR = 8'h08;
	localparam logic [7:0] IRQ_ADDR = 8'h0C;
	localparam logic [7:0] MASK_ADDR = 8'h10;
	localparam logic [7:0] PAGE_ADDR = 8'h14;
	// ctrl bits
	localparam int C_ERASE = 0;
	localparam int C_WRITE = 1;
	localparam int C_CLRBUSY = 2;
	localparam int C_LOCKSET = 3;
	localparam int C_CHIPERASE = 4;
	// status bits
	localparam int S_BUSYCR = 0;
	localparam int S_OPACT = 1;
	localparam int S_HALT = 2;
	// irq bits
	localparam int I_DONE = 0;
	localparam int I_REJECT = 1;
	localparam int IRQ_W = 2;
	localparam logic [3:0] LOCK_RESET = 4'hF;
	localparam logic [1:0] LOCK_FREE = 2'h3;
	localparam logic [1:0] LOCK_NOWR = 2'h2;
	localparam logic [1:0] LOCK_NORD = 2'h1;
	localparam logic [1:0] LOCK_BOTH = 2'h0;
	// ==========================================
	// lock pair decode
	function automatic logic lock_blocks_write(input logic [1:0] p);
		return (p == LOCK_NOWR) || (p == LOCK_BOTH);
	endfunction
	function automatic logic lock_blocks_read(input logic [1:0] p);
		return (p == LOCK_NORD) || (p == LOCK_BOTH);
	endfunction
	// boot section start page for a fuse value
	function automatic logic [PAGE_W-1:0] boot_first(input logic [1:0] sz);
		return PAGE_TOP - ((9'h008 << sz) - 9'h001);
	endfunction
	typedef enum logic [1:0] {SP_IDLE, SP_RUN} sprw_state_t;
endpackage

// ==== rtl/sprw_ctrl.sv ====
/*
 self-program controller: gates page erase/write requests, tracks the
 concurrent-read busy flag, halts the cpu for stalling pages.
 assumes the core reports fetch section and the flash array does the work.
*/
module sprw_ctrl import sprw_pkg::*; #(
	parameter int OP_LEN = OP_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// avalon-mm slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// core side
	input wire logic fetchPc,
	input wire logic [1:0] bootSizeFuses,
	// flash array side
	output logic flashOp,
	output logic [PAGE_W-1:0] flashPage,
	output logic cpuHalt,
	output logic crBlocked,
	output logic irq
);
	// ==========================================
	// fetch section, synchronised (fetchPc high = boot section)
	logic fetchS1_reg, fetchS2_reg;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			fetchS1_reg <= 1'b0;
			fetchS2_reg <= 1'b0;
		end else begin
			fetchS1_reg <= fetchPc;
			fetchS2_reg <= fetchS1_reg;
		end
	end

	// ==========================================
	// register state
	sprw_state_t state_reg, state_next;
	logic [OP_CYCLES_W-1:0] cnt_reg, cnt_next;
	logic busy_reg, busy_next;
	logic halt_reg, halt_next;
	logic [3:0] lock_reg, lock_next;
	logic [IRQ_W-1:0] irqSt_reg, irqSt_next, mask_reg, mask_next;
	logic [PAGE_W-1:0] page_reg, page_next, opPage_reg, opPage_next;
	logic [31:0] rd_reg, rd_next;
	logic ack_reg, ack_next;
	logic irq_reg, irq_next;
	logic waitReq_reg, waitReq_next;
	logic opAct_reg, opAct_next;

	logic wrHit, rdHit, startReq, targetBoot, allowed, isCr;
	logic [PAGE_W-1:0] bootStart;
	logic [IRQ_W-1:0] evt;

	always_comb begin
		// writes land in the answer cycle, when the master sees waitrequest low
		wrHit = write && ack_reg;
		rdHit = read && !ack_reg;
		bootStart = boot_first(bootSizeFuses);
		targetBoot = page_reg >= bootStart;
		isCr = page_reg < STALL_FIRST_PAGE;
		startReq = wrHit && (address == CTRL_ADDR)
			&& (writedata[C_ERASE] || writedata[C_WRITE]);
		// any page reachable from boot, locks permitting
		allowed = fetchS2_reg
			&& !(targetBoot ? lock_blocks_write(lock_reg[3:2])
				: lock_blocks_write(lock_reg[1:0]));
		state_next = state_reg;
		cnt_next = cnt_reg;
		busy_next = busy_reg;
		halt_next = halt_reg;
		opPage_next = opPage_reg;
		lock_next = lock_reg;
		page_next = page_reg;
		mask_next = mask_reg;
		evt = '0;
		// clear only when idle; ahead of the start so a start in one write wins
		if (wrHit && address == CTRL_ADDR && writedata[C_CLRBUSY]
				&& state_reg == SP_IDLE) begin
			busy_next = 1'b0;
		end
		unique case (state_reg)
			SP_IDLE: begin
				if (startReq && allowed) begin
					state_next = SP_RUN;
					cnt_next = OP_CYCLES_W'(OP_LEN - 1);
					opPage_next = page_reg;
					if (isCr) begin
						busy_next = 1'b1;
					end else begin
						halt_next = 1'b1;
					end
				end else if (startReq) begin
					evt[I_REJECT] = 1'b1;
				end
			end
			SP_RUN: begin
				if (cnt_reg == '0) begin
					state_next = SP_IDLE;
					halt_next = 1'b0;
					evt[I_DONE] = 1'b1;
				end else begin
					cnt_next = cnt_reg - 1'b1;
				end
			end
		endcase
		opAct_next = (state_next == SP_RUN);
		// lock bits only programmed to zero; chip erase restores
		if (wrHit && address == LOCK_ADDR) begin
			lock_next = lock_reg & writedata[3:0];
		end
		if (wrHit && address == CTRL_ADDR && writedata[C_CHIPERASE]) begin
			lock_next = LOCK_RESET;
		end
		if (wrHit && address == PAGE_ADDR && state_reg == SP_IDLE) begin
			page_next = writedata[PAGE_W-1:0];
		end
		if (wrHit && address == MASK_ADDR) begin
			mask_next = writedata[IRQ_W-1:0];
		end
		// set wins over write-one clear
		irqSt_next = irqSt_reg;
		if (wrHit && address == IRQ_ADDR) begin
			irqSt_next = irqSt_reg & ~writedata[IRQ_W-1:0];
		end
		irqSt_next = irqSt_next | evt;
		irq_next = |(irqSt_next & mask_next);
		ack_next = (read || write) && !ack_reg;
		waitReq_next = !ack_next;
		rd_next = '0;
		if (rdHit) begin
			unique case (address)
				STAT_ADDR: begin
					rd_next[S_BUSYCR] = busy_reg;
					rd_next[S_OPACT] = (state_reg == SP_RUN);
					rd_next[S_HALT] = halt_reg;
				end
				LOCK_ADDR: rd_next[3:0] = lock_reg;
				IRQ_ADDR: rd_next[IRQ_W-1:0] = irqSt_reg;
				MASK_ADDR: rd_next[IRQ_W-1:0] = mask_reg;
				PAGE_ADDR: rd_next[PAGE_W-1:0] = page_reg;
				default: rd_next = '0;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= SP_IDLE;
			cnt_reg <= '0;
			busy_reg <= 1'b0;
			halt_reg <= 1'b0;
			lock_reg <= LOCK_RESET;
			irqSt_reg <= '0;
			mask_reg <= '0;
			page_reg <= '0;
			opPage_reg <= '0;
			rd_reg <= '0;
			ack_reg <= 1'b0;
			irq_reg <= 1'b0;
			waitReq_reg <= 1'b1;
			opAct_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			busy_reg <= busy_next;
			halt_reg <= halt_next;
			lock_reg <= lock_next;
			irqSt_reg <= irqSt_next;
			mask_reg <= mask_next;
			page_reg <= page_next;
			opPage_reg <= opPage_next;
			rd_reg <= rd_next;
			ack_reg <= ack_next;
			irq_reg <= irq_next;
			waitReq_reg <= waitReq_next;
			opAct_reg <= opAct_next;
		end
	end

	// waitrequest high except the one answer cycle
	always_comb begin
		readdata = rd_reg;
		waitrequest = waitReq_reg;
		flashOp = opAct_reg;
		flashPage = opPage_reg;
		cpuHalt = halt_reg;
		crBlocked = busy_reg;
		irq = irq_reg;
	end

	// ==========================================
	// checks
	sequence s_start_cr;
		state_reg == SP_IDLE && startReq && allowed && isCr;
	endsequence
	a_app_ignored: assert property (@(posedge mclk) disable iff (!arst_n)
		state_reg == SP_IDLE && startReq && !fetchS2_reg |=> state_reg == SP_IDLE)
		else $error("store from application section started an op");
	a_cr_busy_set: assert property (@(posedge mclk) disable iff (!arst_n)
		s_start_cr |=> busy_reg && !halt_reg)
		else $error("busy not set on concurrent page start");
	a_busy_hold: assert property (@(posedge mclk) disable iff (!arst_n)
		state_reg == SP_RUN && busy_reg |=> busy_reg)
		else $error("busy dropped during op");
	a_stall_halt: assert property (@(posedge mclk) disable iff (!arst_n)
		state_reg == SP_IDLE && startReq && allowed && !isCr |=> halt_reg throughout
		(state_reg == SP_RUN)[*2])
		else $error("cpu not halted for stalling page");
	a_halt_end: assert property (@(posedge mclk) disable iff (!arst_n)
		$fell(flashOp) |-> !cpuHalt)
		else $error("halt outlived op");
	a_boot_stall: assert property (@(posedge mclk) disable iff (!arst_n)
		boot_first(bootSizeFuses) >= STALL_FIRST_PAGE)
		else $error("boot section overlaps concurrent section");
	a_lock_sticky: assert property (@(posedge mclk) disable iff (!arst_n)
		!(wrHit && address == CTRL_ADDR && writedata[C_CHIPERASE]) |=>
		(lock_reg & ~$past(lock_reg)) == '0)
		else $error("lock bit cleared without chip erase");
	a_app_lock: assert property (@(posedge mclk) disable iff (!arst_n)
		state_reg == SP_IDLE && startReq && !targetBoot
		&& lock_blocks_write(lock_reg[1:0]) |=> irqSt_reg[I_REJECT])
		else $error("locked application write not refused");

	// ==========================================
	// bus handshake: one answer cycle per request
	a_wait_answer: assert property (@(posedge mclk) disable iff (!arst_n)
		(read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered in the next cycle");
	a_wait_pulse: assert property (@(posedge mclk) disable iff (!arst_n)
		!waitrequest |=> waitrequest)
		else $error("answer stood longer than one cycle");

	// ==========================================
	// section split and sequencing
	sequence s_start_stall;
		state_reg == SP_IDLE && startReq && allowed && !isCr;
	endsequence
	sequence s_reject;
		state_reg == SP_IDLE && startReq && !allowed;
	endsequence
	sequence s_cr_running;
		flashOp && crBlocked && !cpuHalt;
	endsequence
	sequence s_stall_running;
		flashOp && cpuHalt;
	endsequence
	// two cycles suffice here; the split checks cover the rest of the op
	a_cr_run: assert property (@(posedge mclk) disable iff (!arst_n)
		s_start_cr |=> s_cr_running ##1 s_cr_running)
		else $error("cpu halted during concurrent page op");
	a_stall_run: assert property (@(posedge mclk) disable iff (!arst_n)
		s_start_stall |=> s_stall_running ##1 s_stall_running)
		else $error("cpu ran during stalling page op");
	a_split_stall: assert property (@(posedge mclk) disable iff (!arst_n)
		flashOp && opPage_reg >= STALL_FIRST_PAGE |-> cpuHalt)
		else $error("stalling page op without halt");
	a_split_cr: assert property (@(posedge mclk) disable iff (!arst_n)
		flashOp && opPage_reg < STALL_FIRST_PAGE |-> crBlocked && !cpuHalt)
		else $error("concurrent page op without busy or with halt");
	a_halt_source: assert property (@(posedge mclk) disable iff (!arst_n)
		!halt_reg && !(state_reg == SP_IDLE && startReq && allowed && !isCr)
		|=> !halt_reg)
		else $error("halt raised without stalling page start");
	a_busy_source: assert property (@(posedge mclk) disable iff (!arst_n)
		!busy_reg && !(state_reg == SP_IDLE && startReq && allowed && isCr)
		|=> !busy_reg)
		else $error("busy raised without concurrent page start");

	// ==========================================
	// busy clear, locks, target page
	a_busy_clear: assert property (@(posedge mclk) disable iff (!arst_n)
		wrHit && address == CTRL_ADDR && writedata[C_CLRBUSY] && state_reg == SP_IDLE
		&& !(startReq && allowed && isCr) |=> !crBlocked)
		else $error("busy not cleared by idle clear");
	a_busy_keep: assert property (@(posedge mclk) disable iff (!arst_n)
		state_reg == SP_RUN && busy_reg && wrHit && address == CTRL_ADDR
		&& writedata[C_CLRBUSY] |=> crBlocked)
		else $error("busy cleared while op running");
	a_chip_erase: assert property (@(posedge mclk) disable iff (!arst_n)
		wrHit && address == CTRL_ADDR && writedata[C_CHIPERASE] |=> lock_reg == LOCK_RESET)
		else $error("chip erase left lock bits programmed");
	a_boot_any: assert property (@(posedge mclk) disable iff (!arst_n)
		state_reg == SP_IDLE && startReq && fetchS2_reg && lock_reg == LOCK_RESET
		|=> flashOp)
		else $error("unlocked store from boot section refused");
	a_page_latch: assert property (@(posedge mclk) disable iff (!arst_n)
		state_reg == SP_IDLE && startReq && allowed |=> flashPage == $past(page_reg))
		else $error("target page not latched at start");
	a_page_hold: assert property (@(posedge mclk) disable iff (!arst_n)
		state_reg == SP_RUN |=> $stable(flashPage))
		else $error("target page changed during op");

	// ==========================================
	// counter, events, interrupt line
	a_count_bound: assert property (@(posedge mclk) disable iff (!arst_n)
		flashOp |-> cnt_reg <= OP_CYCLES_W'(OP_LEN - 1))
		else $error("op counter beyond op length");
	a_done_flag: assert property (@(posedge mclk) disable iff (!arst_n)
		$fell(flashOp) |-> irqSt_reg[I_DONE])
		else $error("op end did not raise done");
	a_reject_op: assert property (@(posedge mclk) disable iff (!arst_n)
		s_reject |=> !flashOp && irqSt_reg[I_REJECT])
		else $error("refused store started an op");
	// level output: nothing to miss if software polls late
	a_irq_level: assert property (@(posedge mclk) disable iff (!arst_n)
		irq == (|(irqSt_reg & mask_reg)))
		else $error("irq line disagrees with masked status");
endmodule

// ==== sim/sprw_core_model.sv ====
/*
 core model: boot software side of the controller, drives the fetch flag.
 assumes the bench picks boot or application fetch through inBoot.
*/
module sprw_core_model (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// bench and controller
	input wire logic inBoot,
	input wire logic cpuHalt,
	input wire logic crBlocked,
	// results
	output logic fetchPc,
	output int haltCycles,
	output logic crFetchOk
);
	timeunit 1ns;
	timeprecision 1ns;
	assign fetchPc = inBoot;
	// vectors kept in boot code, so no fetch lands in the busy section
	assign crFetchOk = !crBlocked;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) haltCycles <= 0;
		else if (cpuHalt) haltCycles <= haltCycles + 1;
	end
endmodule

// ==== sim/testbench.sv ====
/*
 self-checking bench of the self-program controller.
 assumes sprw_pkg register map and a short op length for speed.
*/
module testbench import sprw_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LEN = 16;
	logic mclk = 0, arst_n = 0, read = 0, write = 0, inBoot = 0, mskOn = 0;
	logic [7:0] address = 8'h00;
	logic [31:0] writedata = 32'h0, readdata, q;
	logic waitrequest, fetchPc, flashOp, cpuHalt, crBlocked, irq, crFetchOk;
	logic [1:0] bootSizeFuses = 2'h3;
	logic [PAGE_W-1:0] flashPage;
	int n_errors = 0, n_tests = 0, haltCycles, cyc = 0;
	sprw_ctrl #(.OP_LEN(LEN)) u_sprw_ctrl (.mclk(mclk), .arst_n(arst_n), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .fetchPc(fetchPc), .bootSizeFuses(bootSizeFuses),
		.flashOp(flashOp), .flashPage(flashPage), .cpuHalt(cpuHalt),
		.crBlocked(crBlocked), .irq(irq));
	sprw_core_model u_sprw_core_model (.mclk(mclk), .arst_n(arst_n), .inBoot(inBoot),
		.cpuHalt(cpuHalt), .crBlocked(crBlocked), .fetchPc(fetchPc),
		.haltCycles(haltCycles), .crFetchOk(crFetchOk));
	// ==========================================
	// clock, watchdog, reporting
	initial forever #20 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			results();
		end
	end
	task results;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// ==========================================
	// avalon master, held until waitrequest low
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		address <= a;
		write <= w;
		read <= !w;
		writedata <= d;
		@(posedge mclk);
		while (waitrequest !== 1'b0) @(posedge mclk);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	// page op: go = must start, hlt = stalling page
	task op(input logic [8:0] pg, input logic [31:0] cmd, input logic go, input logic hlt);
		bus(1'b1, PAGE_ADDR, {23'h0, pg});
		bus(1'b1, CTRL_ADDR, cmd);
		@(negedge mclk);
		chk(32'(flashOp), 32'(go));
		if (go) begin
			chk(32'(flashPage), 32'(pg));
			chk(32'(cpuHalt), 32'(hlt));
			bus(1'b1, CTRL_ADDR, 32'h4);
			// clear while running is ignored
			rdchk(STAT_ADDR, hlt ? 32'h6 : 32'h3);
		end
		repeat (4 * LEN) if (flashOp === 1'b1) @(negedge mclk);
		chk(32'(flashOp), 32'h0);
		rdchk(IRQ_ADDR, go ? 32'h1 : 32'h2);
		chk(32'(irq), 32'(mskOn));
		bus(1'b1, IRQ_ADDR, 32'h3);
		// busy outlives the op until software clears it
		rdchk(STAT_ADDR, {31'h0, go & !hlt});
		chk(32'(irq), 32'h0);
		chk(32'(crFetchOk), 32'(!(go & !hlt)));
		bus(1'b1, CTRL_ADDR, 32'h4);
		rdchk(STAT_ADDR, 32'h0);
	endtask
	// ==========================================
	// scenarios
	task t_app;
		bus(1'b1, MASK_ADDR, 32'h3);
		mskOn = 1'b1;
		op(9'h010, 32'h1, 1'b0, 1'b0);
		bus(1'b1, MASK_ADDR, 32'h0);
		mskOn = 1'b0;
		op(9'h1C0, 32'h2, 1'b0, 1'b0);
		bus(1'b1, MASK_ADDR, 32'h3);
		mskOn = 1'b1;
	endtask
	task t_sections;
		inBoot <= 1'b1;
		repeat (3) @(posedge mclk);
		op(9'h1FF, 32'h2, 1'b1, 1'b1);
		chk(32'(haltCycles), 32'(LEN));
		op(9'h1C0, 32'h1, 1'b1, 1'b1);
		op(9'h1BF, 32'h1, 1'b1, 1'b0);
		op(9'h000, 32'h2, 1'b1, 1'b0);
	endtask
	task t_locks;
		bus(1'b1, LOCK_ADDR, 32'hB);
		op(9'h1C0, 32'h2, 1'b0, 1'b0);
		op(9'h100, 32'h2, 1'b1, 1'b0);
		bootSizeFuses <= 2'h0;
		op(9'h1F0, 32'h1, 1'b1, 1'b1);
		op(9'h1F8, 32'h1, 1'b0, 1'b0);
		bus(1'b1, LOCK_ADDR, 32'h1);
		bus(1'b1, LOCK_ADDR, 32'hF);
		rdchk(LOCK_ADDR, 32'h1);
		op(9'h100, 32'h1, 1'b1, 1'b0);
		op(9'h1FF, 32'h1, 1'b0, 1'b0);
		bus(1'b1, LOCK_ADDR, 32'h0);
		op(9'h100, 32'h1, 1'b0, 1'b0);
		bus(1'b1, CTRL_ADDR, 32'h10);
		rdchk(LOCK_ADDR, 32'hF);
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		rdchk(STAT_ADDR, 32'h0);
		rdchk(LOCK_ADDR, 32'hF);
		chk(32'(irq), 32'h0);
		t_app();
		t_sections();
		t_locks();
		results();
	end
endmodule
